// file: rtl/chain_group_cmd.sv
// How it works
// - Stack read init byte is 0xA0, size zero.
// - Stack write init 0xB0 plus count minus one.
// - Stack write updates up to eight consecutive registers.
// - Stack write executes only on stack members.
// - Stack read answered only by stack members.
// - Top device answers first without waiting.
// - Others append after frame from address N+1.
// - Bad upstream CRC drops own frame, raises fault.
// - Response is data bytes plus six protocol bytes.
// - Response carries own device address.
// - Read data byte is byte count minus one.
// - Every command frame is forwarded up the chain.
// - Broadcast read answered by every device, top down.
// - Broadcast read init byte is 0xC0, size zero.
//
// The APB interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
module chain_group_cmd (
  // System
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  // APB slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [chain_cmd_pkg::APB_ADDR_W-1:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // Command frames from below
  input wire logic CMD_IN_VALID_I,
  input wire logic [7:0] CMD_IN_DATA_I,
  input wire logic CMD_IN_LAST_I,
  // Command frames passed upward
  output logic CMD_OUT_VALID_O,
  output logic [7:0] CMD_OUT_DATA_O,
  output logic CMD_OUT_LAST_O,
  // Response frames from above
  input wire logic RSP_IN_VALID_I,
  input wire logic [7:0] RSP_IN_DATA_I,
  input wire logic RSP_IN_LAST_I,
  // Response frames passed downward
  output logic RSP_OUT_VALID_O,
  output logic [7:0] RSP_OUT_DATA_O,
  output logic RSP_OUT_LAST_O,
  // Device register file
  output logic [chain_cmd_pkg::REG_ADDR_W-1:0] REG_RD_ADDR_O,
  input wire logic [7:0] REG_RD_DATA_I,
  output logic REG_WR_EN_O,
  output logic [chain_cmd_pkg::REG_ADDR_W-1:0] REG_WR_ADDR_O,
  output logic [7:0] REG_WR_DATA_O,
  // Interrupt
  output logic IRQ_O
);
  import chain_cmd_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [31:0] ctrl_q;
  logic stack_member_flag;
  logic chain_top_device;
  logic [7:0] own_addr;
  logic [7:0] above_addr;
  logic apb_wr;
  logic apb_setup;
  logic mapped;
  logic [EV_NUM-1:0] ev_set;
  logic [EV_NUM-1:0] ev_clr;
  logic [EV_NUM-1:0] ev_status;
  logic [EV_NUM-1:0] ev_enable;
  logic cmd_first_q;
  logic [4:0] cmd_idx_q;
  logic [4:0] cmd_pos;
  logic [7:0] cmd_init_q;
  logic [REG_ADDR_W-1:0] cmd_addr_q;
  logic [7:0] cmd_cnt_q;
  logic [4:0] cmd_len_q;
  logic cmd_end_q;
  logic [15:0] cmd_crc;
  logic [7:0] wbuf_q [MAX_WRITE_BYTES];
  logic [7:0] wsh_q [MAX_WRITE_BYTES];
  logic [DATA_SIZE_W-1:0] cmd_size;
  logic cmd_ok;
  logic is_sread;
  logic is_bread;
  logic is_swrite;
  logic rd_go;
  logic wr_go;
  logic [3:0] wr_left_q;
  logic [2:0] wr_ptr_q;
  logic [REG_ADDR_W-1:0] wr_addr_q;
  logic wr_en_q;
  logic [REG_ADDR_W-1:0] wr_out_addr_q;
  logic [7:0] wr_out_data_q;
  logic ri_first_q;
  logic [1:0] ri_idx_q;
  logic [7:0] ri_addr_q;
  logic ri_end_q;
  logic [15:0] ri_crc;
  rsp_state_type rsp_state_q;
  logic [8:0] rsp_cnt_q;
  logic [7:0] rsp_cnt_byte_q;
  logic [REG_ADDR_W-1:0] rsp_base_q;
  logic [REG_ADDR_W-1:0] rd_addr_q;
  logic [9:0] tx_idx_q;
  logic [9:0] tx_data_end;
  logic [9:0] tx_frame_end;
  logic [7:0] tx_byte;
  logic tx_in_data;
  logic tx_crc_en;
  logic [15:0] tx_crc;
  logic [31:0] prdata_d;
  logic [31:0] prdata_q;
  logic [7:0] out_data_q;
  logic out_valid_q;
  logic out_last_q;

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  assign apb_setup = PSEL_I & ~PENABLE_I;
  assign apb_wr = PSEL_I & PENABLE_I & PWRITE_I;
  assign mapped = (PADDR_I == OFS_CTRL) | (PADDR_I == OFS_STATUS) | (PADDR_I == OFS_CLEAR) |
                  (PADDR_I == OFS_ENABLE) | (PADDR_I == OFS_INFO);
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = PSEL_I & PENABLE_I & ~mapped;

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      ctrl_q <= CTRL_RESET;
    end else if (apb_wr && PADDR_I == OFS_CTRL) begin
      ctrl_q <= PWDATA_I;
    end
  end

  // Host must program these before issuing group commands.
  assign stack_member_flag = ctrl_q[CTRL_STACK_MEMBER_BIT];
  assign chain_top_device = ctrl_q[CTRL_TOP_BIT];
  assign own_addr = {2'b00, ctrl_q[CTRL_DEV_ADDR_LSB +: DEV_ADDR_W]};
  assign above_addr = own_addr + 8'h01;
  assign ev_clr = (apb_wr && PADDR_I == OFS_CLEAR) ? PWDATA_I[EV_NUM-1:0] : '0;

  always_comb begin
    prdata_d = 32'h0000_0000;
    case (PADDR_I)
      OFS_CTRL: begin
        prdata_d = ctrl_q;
      end
      OFS_STATUS: begin
        prdata_d[EV_NUM-1:0] = ev_status;
      end
      OFS_ENABLE: begin
        prdata_d[EV_NUM-1:0] = ev_enable;
      end
      OFS_INFO: begin
        prdata_d[INFO_PEND_BIT] = (rsp_state_q == RSP_WAIT);
        prdata_d[INFO_SEND_BIT] = (rsp_state_q == RSP_SEND);
        prdata_d[INFO_WBUSY_BIT] = (wr_left_q != 4'h0);
        prdata_d[INFO_INIT_LSB +: 8] = cmd_init_q;
      end
      default: begin
        prdata_d = 32'h0000_0000;
      end
    endcase
  end

  // Read data is latched in the setup cycle so it comes from a flop.
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      prdata_q <= 32'h0000_0000;
    end else if (apb_setup) begin
      prdata_q <= prdata_d;
    end
  end
  assign PRDATA_O = prdata_q;

  event_irq #(.N(EV_NUM)) u_events (
    .clk_i(CLK_SYS_I),
    .rst_i(RST_I),
    .set_i(ev_set),
    .clr_i(ev_clr),
    .en_wr_i(apb_wr && PADDR_I == OFS_ENABLE),
    .en_data_i(PWDATA_I[EV_NUM-1:0]),
    .status_o(ev_status),
    .enable_o(ev_enable),
    .irq_o(IRQ_O)
  );

  // ----------------------------------------------------------------
  // Command forwarding and parsing
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      CMD_OUT_VALID_O <= 1'b0;
      CMD_OUT_DATA_O <= 8'h00;
      CMD_OUT_LAST_O <= 1'b0;
    end else begin
      CMD_OUT_VALID_O <= CMD_IN_VALID_I;
      CMD_OUT_DATA_O <= CMD_IN_DATA_I;
      CMD_OUT_LAST_O <= CMD_IN_VALID_I & CMD_IN_LAST_I;
    end
  end

  assign cmd_pos = cmd_first_q ? 5'd0 : cmd_idx_q;

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      cmd_first_q <= 1'b1;
      cmd_idx_q <= 5'd0;
      cmd_end_q <= 1'b0;
      cmd_len_q <= 5'd0;
    end else begin
      cmd_end_q <= CMD_IN_VALID_I & CMD_IN_LAST_I;
      if (CMD_IN_VALID_I) begin
        cmd_first_q <= CMD_IN_LAST_I;
        if (cmd_pos != 5'd31) begin
          cmd_idx_q <= cmd_pos + 5'd1;
        end
        if (CMD_IN_LAST_I) begin
          cmd_len_q <= cmd_pos + 5'd1;
        end
      end
    end
  end

  // No device address byte follows the init byte of a group command.
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      cmd_init_q <= 8'h00;
      cmd_addr_q <= '0;
      cmd_cnt_q <= 8'h00;
    end else if (CMD_IN_VALID_I) begin
      if (cmd_pos == 5'd0) begin
        cmd_init_q <= CMD_IN_DATA_I;
      end
      if (cmd_pos == 5'(CMD_POS_ADDR_HI)) begin
        cmd_addr_q[15:8] <= CMD_IN_DATA_I;
      end
      if (cmd_pos == 5'(CMD_POS_ADDR_LO)) begin
        cmd_addr_q[7:0] <= CMD_IN_DATA_I;
      end
      if (cmd_pos == 5'(CMD_POS_DATA)) begin
        cmd_cnt_q <= CMD_IN_DATA_I;
      end
    end
  end

  for (genvar i = 0; i < MAX_WRITE_BYTES; i++) begin : g_wbuf
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
      if (RST_I) begin
        wbuf_q[i] <= 8'h00;
      end else if (CMD_IN_VALID_I && cmd_pos == 5'(CMD_POS_DATA + i)) begin
        wbuf_q[i] <= CMD_IN_DATA_I;
      end
    end
  end

  frame_crc16 u_cmd_crc (
    .clk_i(CLK_SYS_I),
    .rst_i(RST_I),
    .en_i(CMD_IN_VALID_I),
    .first_i(cmd_first_q),
    .data_i(CMD_IN_DATA_I),
    .crc_o(cmd_crc)
  );

  // Only a frame whose check remainder comes out clean is executed.
  assign cmd_ok = (cmd_crc == CRC_GOOD_RESIDUE);
  assign cmd_size = cmd_init_q[DATA_SIZE_LSB +: DATA_SIZE_W];
  assign is_sread = (cmd_init_q == INIT_STACK_READ) && (cmd_len_q == 5'(CMD_READ_LEN));
  assign is_bread = (cmd_init_q == INIT_BCAST_READ) && (cmd_len_q == 5'(CMD_READ_LEN));
  assign is_swrite = cmd_init_q[FRAME_TYPE_BIT] &&
                     (cmd_init_q[REQ_TYPE_LSB +: REQ_TYPE_W] == REQ_STACK_WRITE) &&
                     (cmd_init_q[7:DATA_SIZE_W] == INIT_STACK_WRITE_BASE[7:DATA_SIZE_W]) &&
                     (cmd_len_q == 5'(cmd_size) + 5'(CMD_WRITE_OVERHEAD + 1));
  assign wr_go = cmd_end_q & cmd_ok & is_swrite & stack_member_flag;
  assign rd_go = cmd_end_q & cmd_ok & ((is_sread & stack_member_flag) | is_bread);

  // ----------------------------------------------------------------
  // Stack write engine
  // ----------------------------------------------------------------
  // The payload is copied out so the next frame may arrive during the writes.
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      wr_left_q <= 4'h0;
      wr_ptr_q <= 3'd0;
      wr_addr_q <= '0;
      wr_en_q <= 1'b0;
      wr_out_addr_q <= '0;
      wr_out_data_q <= 8'h00;
      for (int i = 0; i < MAX_WRITE_BYTES; i++) begin
        wsh_q[i] <= 8'h00;
      end
    end else begin
      wr_en_q <= 1'b0;
      if (wr_go) begin
        wr_left_q <= 4'(cmd_size) + 4'h1;
        wr_ptr_q <= 3'd0;
        wr_addr_q <= cmd_addr_q;
        wsh_q <= wbuf_q;
      end else if (wr_left_q != 4'h0) begin
        wr_en_q <= 1'b1;
        wr_out_addr_q <= wr_addr_q;
        wr_out_data_q <= wsh_q[wr_ptr_q];
        wr_addr_q <= wr_addr_q + 16'h0001;
        wr_ptr_q <= wr_ptr_q + 3'd1;
        wr_left_q <= wr_left_q - 4'h1;
      end
    end
  end

  assign REG_WR_EN_O = wr_en_q;
  assign REG_WR_ADDR_O = wr_out_addr_q;
  assign REG_WR_DATA_O = wr_out_data_q;

  // ----------------------------------------------------------------
  // Upstream response monitor
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      ri_first_q <= 1'b1;
      ri_idx_q <= 2'd0;
      ri_addr_q <= 8'h00;
      ri_end_q <= 1'b0;
    end else begin
      ri_end_q <= RSP_IN_VALID_I & RSP_IN_LAST_I;
      if (RSP_IN_VALID_I) begin
        ri_first_q <= RSP_IN_LAST_I;
        ri_idx_q <= ri_first_q ? 2'd1 : ((ri_idx_q == 2'd3) ? 2'd3 : ri_idx_q + 2'd1);
        if (!ri_first_q && ri_idx_q == 2'(RSP_POS_ADDR)) begin
          ri_addr_q <= RSP_IN_DATA_I;
        end
      end
    end
  end

  frame_crc16 u_rsp_in_crc (
    .clk_i(CLK_SYS_I),
    .rst_i(RST_I),
    .en_i(RSP_IN_VALID_I),
    .first_i(ri_first_q),
    .data_i(RSP_IN_DATA_I),
    .crc_o(ri_crc)
  );

  // ----------------------------------------------------------------
  // Own response
  // ----------------------------------------------------------------
  assign tx_data_end = 10'(rsp_cnt_q) + 10'(RSP_HDR_BYTES);
  assign tx_frame_end = 10'(rsp_cnt_q) + 10'(RSP_PROTO_BYTES - 1);
  assign tx_in_data = (tx_idx_q >= 10'(RSP_HDR_BYTES)) && (tx_idx_q < tx_data_end);
  assign tx_crc_en = (rsp_state_q == RSP_SEND) && (tx_idx_q < tx_data_end);

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      rsp_state_q <= RSP_IDLE;
      rsp_cnt_q <= 9'd0;
      rsp_cnt_byte_q <= 8'h00;
      rsp_base_q <= '0;
      rd_addr_q <= '0;
      tx_idx_q <= 10'd0;
    end else begin
      case (rsp_state_q)
        RSP_IDLE: begin
          tx_idx_q <= 10'd0;
        end
        RSP_WAIT: begin
          if (ri_end_q && ri_addr_q == above_addr) begin
            rsp_state_q <= (ri_crc == CRC_GOOD_RESIDUE) ? RSP_SEND : RSP_IDLE;
          end
        end
        RSP_SEND: begin
          tx_idx_q <= tx_idx_q + 10'd1;
          if (tx_in_data) begin
            rd_addr_q <= rd_addr_q + 16'h0001;
          end
          if (tx_idx_q == tx_frame_end) begin
            rsp_state_q <= RSP_IDLE;
          end
        end
        default: begin
          rsp_state_q <= RSP_IDLE;
        end
      endcase
      if (rd_go) begin
        rsp_cnt_q <= 9'(cmd_cnt_q) + 9'd1;
        rsp_cnt_byte_q <= cmd_cnt_q;
        rsp_base_q <= cmd_addr_q;
        rd_addr_q <= cmd_addr_q;
        tx_idx_q <= 10'd0;
        rsp_state_q <= chain_top_device ? RSP_SEND : RSP_WAIT;
      end
    end
  end

  always_comb begin
    tx_byte = REG_RD_DATA_I;
    if (tx_idx_q == 10'd0) begin
      tx_byte = rsp_cnt_byte_q;
    end else if (tx_idx_q == 10'(RSP_POS_ADDR)) begin
      tx_byte = own_addr;
    end else if (tx_idx_q == 10'(RSP_POS_ADDR + 1)) begin
      tx_byte = rsp_base_q[15:8];
    end else if (tx_idx_q == 10'(RSP_POS_ADDR + 2)) begin
      tx_byte = rsp_base_q[7:0];
    end else if (tx_idx_q == tx_data_end) begin
      tx_byte = tx_crc[7:0];
    end else if (tx_idx_q > tx_data_end) begin
      tx_byte = tx_crc[15:8];
    end
  end

  frame_crc16 u_tx_crc (
    .clk_i(CLK_SYS_I),
    .rst_i(RST_I),
    .en_i(tx_crc_en),
    .first_i(tx_idx_q == 10'd0),
    .data_i(tx_byte),
    .crc_o(tx_crc)
  );

  assign REG_RD_ADDR_O = rd_addr_q;

  // Own frame takes the link; upstream bytes are not expected while it is sent.
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      out_valid_q <= 1'b0;
      out_data_q <= 8'h00;
      out_last_q <= 1'b0;
    end else if (rsp_state_q == RSP_SEND) begin
      out_valid_q <= 1'b1;
      out_data_q <= tx_byte;
      out_last_q <= (tx_idx_q == tx_frame_end);
    end else begin
      out_valid_q <= RSP_IN_VALID_I;
      out_data_q <= RSP_IN_DATA_I;
      out_last_q <= RSP_IN_VALID_I & RSP_IN_LAST_I;
    end
  end

  assign RSP_OUT_VALID_O = out_valid_q;
  assign RSP_OUT_DATA_O = out_data_q;
  assign RSP_OUT_LAST_O = out_last_q;

  // ----------------------------------------------------------------
  // Events
  // ----------------------------------------------------------------
  always_comb begin
    ev_set = '0;
    ev_set[EV_RSP_CRC_FAULT] = (rsp_state_q == RSP_WAIT) && ri_end_q && (ri_addr_q == above_addr) &&
                               (ri_crc != CRC_GOOD_RESIDUE) && !rd_go;
    ev_set[EV_CMD_CRC_ERR] = cmd_end_q & ~cmd_ok;
    ev_set[EV_WRITE_DONE] = wr_en_q & (wr_left_q == 4'h0) & ~wr_go;
    ev_set[EV_RSP_SENT] = (rsp_state_q == RSP_SEND) && (tx_idx_q == tx_frame_end) && !rd_go;
  end

endmodule // chain_group_cmd

// file: rtl/chain_cmd_pkg.sv
package chain_cmd_pkg;

  // ----------------------------------------------------------------
  // Frame coding
  // ----------------------------------------------------------------
  localparam logic [7:0] INIT_STACK_READ = 8'hA0;
  localparam logic [7:0] INIT_STACK_WRITE_BASE = 8'hB0;
  localparam logic [7:0] INIT_BCAST_READ = 8'hC0;
  localparam logic [2:0] REQ_STACK_WRITE = 3'h3;
  localparam int FRAME_TYPE_BIT = 7;
  localparam int REQ_TYPE_LSB = 4;
  localparam int DATA_SIZE_LSB = 0;
  localparam int REQ_TYPE_W = 3;
  localparam int DATA_SIZE_W = 3;
  localparam int MAX_WRITE_BYTES = 8;
  localparam int CMD_POS_ADDR_HI = 1;
  localparam int CMD_POS_ADDR_LO = 2;
  localparam int CMD_POS_DATA = 3;
  localparam int CMD_READ_LEN = 6;
  localparam int CMD_WRITE_OVERHEAD = 5;
  localparam int RSP_POS_ADDR = 1;
  localparam int RSP_HDR_BYTES = 4;
  localparam int RSP_PROTO_BYTES = 6;
  localparam int REG_ADDR_W = 16;
  localparam int BYTE_W = 8;

  // ----------------------------------------------------------------
  // Frame check
  // ----------------------------------------------------------------
  localparam logic [15:0] CRC_POLY_REFL = 16'hA001;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_GOOD_RESIDUE = 16'h0000;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int APB_ADDR_W = 12;
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_CLEAR = 12'h008;
  localparam logic [11:0] OFS_ENABLE = 12'h00C;
  localparam logic [11:0] OFS_INFO = 12'h010;
  localparam int CTRL_STACK_MEMBER_BIT = 0;
  localparam int CTRL_TOP_BIT = 1;
  localparam int CTRL_DEV_ADDR_LSB = 8;
  localparam int DEV_ADDR_W = 6;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [3:0] ENABLE_RESET = 4'h0;
  localparam int EV_RSP_CRC_FAULT = 0;
  localparam int EV_CMD_CRC_ERR = 1;
  localparam int EV_WRITE_DONE = 2;
  localparam int EV_RSP_SENT = 3;
  localparam int EV_NUM = 4;
  localparam int INFO_PEND_BIT = 0;
  localparam int INFO_SEND_BIT = 1;
  localparam int INFO_WBUSY_BIT = 2;
  localparam int INFO_INIT_LSB = 8;

  typedef enum logic [1:0] {RSP_IDLE, RSP_WAIT, RSP_SEND} rsp_state_type;

endpackage

// file: rtl/frame_crc16.sv
`timescale 1ns/100ps
module frame_crc16 (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Byte stream
  input wire logic en_i,
  input wire logic first_i,
  input wire logic [7:0] data_i,
  // Running remainder
  output logic [15:0] crc_o
);
  import chain_cmd_pkg::*;

  logic [15:0] crc_d;

  always_comb begin
    crc_d = (first_i ? CRC_INIT : crc_o) ^ {8'h00, data_i};
    for (int b = 0; b < 8; b++) begin
      crc_d = crc_d[0] ? ((crc_d >> 1) ^ CRC_POLY_REFL) : (crc_d >> 1);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      crc_o <= CRC_INIT;
    end else if (en_i) begin
      crc_o <= crc_d;
    end
  end

endmodule // frame_crc16

// file: rtl/event_irq.sv
`timescale 1ns/100ps
module event_irq #(
  parameter int N = 4
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Events and software access
  input wire logic [N-1:0] set_i,
  input wire logic [N-1:0] clr_i,
  input wire logic en_wr_i,
  input wire logic [N-1:0] en_data_i,
  // State
  output logic [N-1:0] status_o,
  output logic [N-1:0] enable_o,
  output logic irq_o
);
  import chain_cmd_pkg::*;

  // Set wins over a clear in the same cycle so that no event is lost.
  for (genvar i = 0; i < N; i++) begin : g_bit
    always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
        status_o[i] <= 1'b0;
      end else begin
        status_o[i] <= set_i[i] | (status_o[i] & ~clr_i[i]);
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      enable_o <= N'(ENABLE_RESET);
    end else if (en_wr_i) begin
      enable_o <= en_data_i;
    end
  end

  assign irq_o = |(status_o & enable_o);

endmodule // event_irq

// file: verification/chain_group_cmd_asserts.sv
`timescale 1ns/100ps
module chain_group_cmd_chk (
  // Clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  // Watched ports
  input wire logic CMD_IN_VALID_I,
  input wire logic [7:0] CMD_IN_DATA_I,
  input wire logic CMD_IN_LAST_I,
  input wire logic CMD_OUT_VALID_O,
  input wire logic [7:0] CMD_OUT_DATA_O,
  input wire logic CMD_OUT_LAST_O,
  input wire logic RSP_IN_VALID_I,
  input wire logic [7:0] RSP_IN_DATA_I,
  input wire logic RSP_OUT_VALID_O,
  input wire logic [7:0] RSP_OUT_DATA_O,
  input wire logic RSP_OUT_LAST_O,
  input wire logic REG_WR_EN_O,
  input wire logic [chain_cmd_pkg::REG_ADDR_W-1:0] REG_WR_ADDR_O
);
  import chain_cmd_pkg::*;
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);
  AST_FWD_VALID: assert property (CMD_IN_VALID_I |=> CMD_OUT_VALID_O)
    else $error("command byte not forwarded");
  AST_FWD_DATA: assert property (CMD_IN_VALID_I |=>
    CMD_OUT_DATA_O == $past(CMD_IN_DATA_I) && CMD_OUT_LAST_O == $past(CMD_IN_LAST_I))
    else $error("forwarded byte differs");
  AST_WR_ADDR: assert property (REG_WR_EN_O && $past(REG_WR_EN_O) |->
    REG_WR_ADDR_O == $past(REG_WR_ADDR_O) + 16'h0001)
    else $error("write address not consecutive");
  AST_WR_BURST: assert property (REG_WR_EN_O [*8] |=> !REG_WR_EN_O)
    else $error("write burst above eight");
  AST_WR_AFTER: assert property ($rose(REG_WR_EN_O) |->
    $past(CMD_OUT_LAST_O) || $past(CMD_OUT_LAST_O, 2))
    else $error("write without a finished frame");
  AST_RSP_END: assert property ($fell(RSP_OUT_VALID_O) |-> $past(RSP_OUT_LAST_O))
    else $error("response broken off");
  AST_PASS: assert property (RSP_IN_VALID_I |=>
    RSP_OUT_VALID_O && RSP_OUT_DATA_O == $past(RSP_IN_DATA_I))
    else $error("upstream byte not passed");
  AST_RSP_LEN: assert property ($rose(RSP_OUT_VALID_O) |-> ##[6:300] RSP_OUT_LAST_O)
    else $error("response frame too short or endless");
  cover property (REG_WR_EN_O [*4]);
  cover property ($rose(RSP_OUT_VALID_O));
  cover property (RSP_IN_VALID_I ##1 RSP_OUT_LAST_O);
endmodule // chain_group_cmd_chk

bind chain_group_cmd chain_group_cmd_chk u_chk (.CLK_SYS_I, .RST_I, .CMD_IN_VALID_I, .CMD_IN_DATA_I,
  .CMD_IN_LAST_I, .CMD_OUT_VALID_O, .CMD_OUT_DATA_O, .CMD_OUT_LAST_O, .RSP_IN_VALID_I, .RSP_IN_DATA_I,
  .RSP_OUT_VALID_O, .RSP_OUT_DATA_O, .RSP_OUT_LAST_O, .REG_WR_EN_O, .REG_WR_ADDR_O);

// file: verification/chain_peer.sv
`timescale 1ns/100ps
module chain_peer (
  // Clock
  input wire logic clk_i,
  // Command stream from the host side
  output logic cmd_valid_o,
  output logic [7:0] cmd_data_o,
  output logic cmd_last_o,
  // Response stream from the device above
  output logic rsp_valid_o,
  output logic [7:0] rsp_data_o,
  output logic rsp_last_o,
  // Register file
  input wire logic [15:0] rd_addr_i,
  output logic [7:0] rd_data_o
);
  typedef logic [7:0] bq_type [$];
  initial {cmd_valid_o, cmd_data_o, cmd_last_o, rsp_valid_o, rsp_data_o, rsp_last_o} = '0;
  // Contents follow the address so that every byte read back can be predicted.
  assign rd_data_o = rd_addr_i[7:0] ^ 8'h5A;
  function automatic logic [15:0] crc16(input bq_type b);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (b[i]) begin
      c = c ^ {8'h00, b[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
    end
    return c;
  endfunction
  task automatic send(input bit rsp, input bq_type b, input bit bad);
    logic [15:0] c;
    c = crc16(b) ^ {15'h0, bad};
    b.push_back(c[7:0]);
    b.push_back(c[15:8]);
    foreach (b[i]) begin
      @(posedge clk_i);
      if (rsp) {rsp_valid_o, rsp_data_o, rsp_last_o} <= {1'b1, b[i], i == b.size() - 1};
      else {cmd_valid_o, cmd_data_o, cmd_last_o} <= {1'b1, b[i], i == b.size() - 1};
    end
    // Idle data lines toggle so that a stale byte is never mistaken for a live one.
    @(posedge clk_i);
    if (rsp) {rsp_valid_o, rsp_data_o, rsp_last_o} <= {1'b0, ~c[15:8], 1'b0};
    else {cmd_valid_o, cmd_data_o, cmd_last_o} <= {1'b0, ~c[15:8], 1'b0};
  endtask
endmodule // chain_peer

// file: verification/tb.sv
`timescale 1ns/100ps
module tb;
  import chain_cmd_pkg::*;
  typedef logic [7:0] bq_type [$];
  typedef struct {logic [7:0] init; logic [7:0] cnt; logic mem; logic top; int nwr; int nrsp;} row_type;
  logic CLK_SYS_I = 1'b0, RST_I = 1'b1, PSEL_I = 1'b0, PENABLE_I = 1'b0, PWRITE_I = 1'b0;
  logic [11:0] PADDR_I = '0;
  logic [31:0] PWDATA_I = '0, PRDATA_O, rd;
  logic PREADY_O, PSLVERR_O, CMD_IN_VALID_I, CMD_IN_LAST_I, CMD_OUT_VALID_O, CMD_OUT_LAST_O, err;
  logic RSP_IN_VALID_I, RSP_IN_LAST_I, RSP_OUT_VALID_O, RSP_OUT_LAST_O, REG_WR_EN_O, IRQ_O;
  logic [7:0] CMD_IN_DATA_I, CMD_OUT_DATA_O, RSP_IN_DATA_I, RSP_OUT_DATA_O, REG_RD_DATA_I, REG_WR_DATA_O;
  logic [15:0] REG_RD_ADDR_O, REG_WR_ADDR_O;
  int error_cnt = 0, samples_checked = 0;
  bq_type rq;
  logic [23:0] wq [$];
  row_type rows [6] = '{
    '{8'hB3, 8'h00, 1, 0, 4, 0},
    '{8'hB7, 8'h00, 1, 0, 8, 0},
    '{8'hB0, 8'h00, 0, 1, 0, 0},
    '{8'hA0, 8'h1F, 1, 1, 0, 38},
    '{8'hA0, 8'h00, 0, 1, 0, 0},
    '{8'hC0, 8'h02, 0, 1, 0, 9}};
  chain_group_cmd uut (.CLK_SYS_I, .RST_I, .PSEL_I, .PENABLE_I, .PWRITE_I, .PADDR_I, .PWDATA_I, .PRDATA_O,
    .PREADY_O, .PSLVERR_O, .CMD_IN_VALID_I, .CMD_IN_DATA_I, .CMD_IN_LAST_I, .CMD_OUT_VALID_O, .CMD_OUT_DATA_O,
    .CMD_OUT_LAST_O, .RSP_IN_VALID_I, .RSP_IN_DATA_I, .RSP_IN_LAST_I, .RSP_OUT_VALID_O, .RSP_OUT_DATA_O,
    .RSP_OUT_LAST_O, .REG_RD_ADDR_O, .REG_RD_DATA_I, .REG_WR_EN_O, .REG_WR_ADDR_O, .REG_WR_DATA_O, .IRQ_O);
  chain_peer peer (.clk_i(CLK_SYS_I), .cmd_valid_o(CMD_IN_VALID_I), .cmd_data_o(CMD_IN_DATA_I),
    .cmd_last_o(CMD_IN_LAST_I), .rsp_valid_o(RSP_IN_VALID_I), .rsp_data_o(RSP_IN_DATA_I),
    .rsp_last_o(RSP_IN_LAST_I), .rd_addr_i(REG_RD_ADDR_O), .rd_data_o(REG_RD_DATA_I));
  always #4 CLK_SYS_I = ~CLK_SYS_I;
  always @(posedge CLK_SYS_I) begin
    if (RSP_OUT_VALID_O === 1'b1) rq.push_back(RSP_OUT_DATA_O);
    if (REG_WR_EN_O === 1'b1) wq.push_back({REG_WR_ADDR_O, REG_WR_DATA_O});
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge CLK_SYS_I);
    {PSEL_I, PENABLE_I, PWRITE_I, PADDR_I, PWDATA_I} <= {2'b10, w, a, wd};
    @(posedge CLK_SYS_I);
    PENABLE_I <= 1'b1;
    do @(posedge CLK_SYS_I); while (PREADY_O !== 1'b1);
    rd = PRDATA_O;
    err = PSLVERR_O;
    {PSEL_I, PENABLE_I} <= 2'b00;
  endtask
  task automatic run(input logic [7:0] init, input logic [7:0] cnt);
    bq_type q;
    q = {init, 8'h03, 8'h00};
    if (init[7:4] == 4'hB) for (int i = 0; i <= init[2:0]; i++) q.push_back(8'h10 + i[7:0]);
    else q.push_back(cnt);
    rq.delete();
    wq.delete();
    peer.send(1'b0, q, 1'b0);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge CLK_SYS_I);
    error_cnt++;
    end_of_test();
  end
  initial begin
    repeat (3) @(posedge CLK_SYS_I);
    RST_I <= 1'b0;
    apb(1'b0, OFS_CTRL, 32'h0);
    chk(rd, CTRL_RESET);
    apb(1'b0, 12'h020, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    $display("reset case done");
    foreach (rows[k]) begin
      apb(1'b1, OFS_CTRL, {18'h0, 6'd5, 6'h0, rows[k].top, rows[k].mem});
      run(rows[k].init, rows[k].cnt);
      repeat (60) @(posedge CLK_SYS_I);
      chk(wq.size(), rows[k].nwr);
      foreach (wq[i]) chk(wq[i], {16'h0300 + i[15:0], 8'h10 + i[7:0]});
      chk(rq.size(), rows[k].nrsp);
      if (rq.size() > 6) begin
        chk(rq[0], rows[k].cnt);
        chk(rq[1], 8'h05);
        chk(rq[rq.size() - 3], rows[k].cnt ^ 8'h5A);
        chk(peer.crc16(rq), 16'h0000);
      end
      $display("row %0d done", k);
    end
    apb(1'b1, OFS_ENABLE, 32'h1);
    apb(1'b1, OFS_CTRL, 32'h0501);
    for (int b = 0; b < 2; b++) begin
      run(8'hA0, 8'h00);
      repeat (5) @(posedge CLK_SYS_I);
      peer.send(1'b1, {8'h00, 8'h06, 8'h03, 8'h00, 8'hEE}, b[0]);
      repeat (40) @(posedge CLK_SYS_I);
      chk(rq.size(), b ? 7 : 14);
      chk(IRQ_O, b);
      if (b == 0) chk(rq[8], 8'h05);
      $display("upstream case %0d done", b);
    end
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd[0], 1'b1);
    apb(1'b1, OFS_CLEAR, 32'h1);
    @(posedge CLK_SYS_I);
    chk(IRQ_O, 1'b0);
    $display("interrupt case done");
    peer.send(1'b0, {8'hB3, 8'h03, 8'h00, 8'h10, 8'h11, 8'h12, 8'h13}, 1'b1);
    repeat (20) @(posedge CLK_SYS_I);
    chk(wq.size(), 0);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd[1], 1'b1);
    $display("bad frame case done");
    RST_I <= 1'b1;
    repeat (3) @(posedge CLK_SYS_I);
    RST_I <= 1'b0;
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, OFS_ENABLE, 32'h0);
    chk(rd, ENABLE_RESET);
    $display("mid-run reset case done");
    end_of_test();
  end
endmodule // tb
